/* logic/fma_defines.vh */
// constants for the fault monitor aggregator
`ifndef FMA_DEFINES_VH
`define FMA_DEFINES_VH

// register byte offsets
`define FMA_OFF_DIAG0 8'h00
`define FMA_OFF_DIAG1 8'h04
`define FMA_OFF_CTRL 8'h08
`define FMA_OFF_IRQ_STAT 8'h0C
`define FMA_OFF_IRQ_MASK 8'h10

// latched fault vector positions
`define FMA_LAT_SUPPLY 0
`define FMA_LAT_HOT 1
`define FMA_LAT_COLD 2
`define FMA_LAT_TSD 3
`define FMA_LAT_SHORT_LO 4
`define FMA_LAT_SHORT_HI 7
`define FMA_LAT_OPEN_LO 8
`define FMA_LAT_OPEN_HI 9
`define FMA_LAT_STALL 10
`define FMA_LAT_W 11

// diagnostic register field positions
`define FMA_STATUS_INDICATOR_PIN_SUMMARY 15
`define FMA_STATUS_INDICATOR_PIN_SUPPLY 14
`define FMA_D0_SHORT_HI 13
`define FMA_D0_SHORT_LO 10
`define FMA_D0_OPEN_HI 9
`define FMA_D0_OPEN_LO 8
`define FMA_D1_TSD 13
`define FMA_D1_HOT 12
`define FMA_D1_COLD 11
`define FMA_D1_STALL 10

// interrupt event positions
`define FMA_EV_SUPPLY 0
`define FMA_EV_HOT 1
`define FMA_EV_COLD 2
`define FMA_EV_TSD 3
`define FMA_EV_SHORT 4
`define FMA_EV_OPEN 5
`define FMA_EV_STALL 6
`define FMA_EV_W 7

// control register fields and reset values
`define FMA_CTRL_SEL_LO 0
`define FMA_CTRL_SEL_HI 1
`define FMA_CTRL_RST 2'h0
`define FMA_MASK_RST 7'h00

// status pin source selection codes
`define FMA_SEL_FAULT 2'h0
`define FMA_SEL_STALL 2'h1
`define FMA_SEL_PWMA 2'h2
`define FMA_SEL_TEMP 2'h3

// synchroniser width for comparator inputs
`define FMA_SYNC_W 12

`endif

/* logic/fma_sync.v */
// two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
`default_nettype none

module fma_sync #(
    parameter WIDTH = 12
) (
    // clock, reset, enable
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    // levels in and out
    input wire [WIDTH-1:0] d_i,
    output wire [WIDTH-1:0] q_o
);

    genvar g;

    // one flop pair per bit, first stage feeds only the second
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            always @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else if (ce_i) begin
                    meta_q <= d_i[g];
                    sync_q <= meta_q;
                end
            end
            assign q_o[g] = sync_q;
        end
    endgenerate

endmodule // fma_sync

`default_nettype wire

/* logic/fma_top.v */
// fault monitor aggregator: fault latching, output disable, status pin, apb registers
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fma_defines.vh"

module fma_top #(
    parameter ADDR_W = 8
) (
    // clock, reset, enable
    input wire clk_i,
    input wire rst_n_i,
    input wire ce_i,
    // apb slave
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [ADDR_W-1:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    // analog comparator indications, asynchronous, high when active
    input wire logic_uv_i,
    input wire regulator_output_uv_i,
    input wire motor_supply_uv_i,
    input wire hot_warn_i,
    input wire cold_warn_i,
    input wire overtemp_i,
    input wire [3:0] short_i,
    input wire [1:0] open_load_i,
    input wire stall_i,
    // synchronous pin inputs
    input wire step_i,
    input wire hard_clear_n_i,
    input wire frame_select_n_i,
    input wire pwm_a_on_i,
    // bridge and supply control
    output wire bridge_en_a_o,
    output wire bridge_en_b_o,
    output wire regulator_output_thr_low_o,
    // status and serial outputs
    output wire fault_live_n_o,
    output wire status_indicator_pin_o,
    output wire temp_analog_sel_o,
    output wire serial_first_bit_o,
    output wire irq_o
);

    // reset synchroniser state
    reg rst_meta_q;
    reg rst_sync_q;
    wire rst_raw_n;
    wire rst_n;

    // synchronised comparator levels
    wire [`FMA_SYNC_W-1:0] async_vec;
    wire [`FMA_SYNC_W-1:0] sync_vec;
    wire s_regulator_output;
    wire s_vbb;
    wire s_hot;
    wire s_cold;
    wire s_ot;
    wire [3:0] s_short;
    wire [1:0] s_open;
    wire s_stall;

    // fault state
    reg [`FMA_LAT_W-1:0] lat_q;
    reg [`FMA_LAT_W-1:0] lat_d;
    wire [`FMA_LAT_W-1:0] lat_set;
    reg [1:0] short_dis_q;
    reg [1:0] short_dis_d;
    wire [1:0] short_set;
    reg step_q;
    wire step_rise;
    wire status_indicator_pin_clr;
    wire summary;
    wire supply_low;
    wire fault_any;

    // output registers
    reg bridge_en_a_q;
    reg bridge_en_b_q;
    reg thr_low_q;
    reg fault_live_n_q;
    reg pin_q;
    reg pin_d;
    reg temp_sel_q;
    reg irq_q;

    // apb and software registers
    reg [1:0] ctrl_sel_q;
    reg [`FMA_EV_W-1:0] irq_stat_q;
    reg [`FMA_EV_W-1:0] irq_stat_d;
    reg [`FMA_EV_W-1:0] irq_mask_q;
    reg [`FMA_EV_W-1:0] ev_prev_q;
    wire [`FMA_EV_W-1:0] ev_src;
    wire [`FMA_EV_W-1:0] ev_rise;
    reg rdy_q;
    reg err_q;
    reg [31:0] prdata_q;
    reg [31:0] rd_data;
    reg rd_err;
    wire acc;
    wire done;
    wire wr_done;
    wire [15:0] diag0;
    wire [15:0] diag1;

    // logic undervoltage acts as a power-on reset of the whole block
    assign rst_raw_n = rst_n_i & ~logic_uv_i;

    // reset release through two flops
    always @(posedge clk_i or negedge rst_raw_n) begin
        if (!rst_raw_n) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_q;

    // comparator levels into the clock domain
    assign async_vec = {stall_i, open_load_i, short_i, overtemp_i, cold_warn_i,
                        hot_warn_i, motor_supply_uv_i, regulator_output_uv_i};

    fma_sync #(
        .WIDTH(`FMA_SYNC_W)
    ) u_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .ce_i(ce_i),
        .d_i(async_vec),
        .q_o(sync_vec)
    );

    // split of the synchronised vector
    assign s_regulator_output = sync_vec[0];
    assign s_vbb = sync_vec[1];
    assign s_hot = sync_vec[2];
    assign s_cold = sync_vec[3];
    assign s_ot = sync_vec[4];
    assign s_short = sync_vec[8:5];
    assign s_open = sync_vec[10:9];
    assign s_stall = sync_vec[11];

    // shared undervoltage indication
    assign supply_low = s_regulator_output | s_vbb;

    // step edge detect
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            step_q <= 1'b0;
        end else if (ce_i) begin
            step_q <= step_i;
        end
    end
    assign step_rise = step_i & ~step_q;

    // diagnostic reset sources
    assign status_indicator_pin_clr = ~hard_clear_n_i | wr_done;

    // latched fault bits, set wins over clear
    assign lat_set = {s_stall, s_open, s_short, s_ot, s_cold, s_hot, supply_low};
    always @* begin
        lat_d = lat_q;
        if (status_indicator_pin_clr) begin
            lat_d = {`FMA_LAT_W{1'b0}};
        end
        lat_d = lat_d | lat_set;
    end

    // short disable per phase, released by step edge or diagnostic reset
    assign short_set[0] = s_short[0] | s_short[1];
    assign short_set[1] = s_short[2] | s_short[3];
    always @* begin
        short_dis_d = short_dis_q;
        if (step_rise || status_indicator_pin_clr) begin
            short_dis_d = 2'h0;
        end
        short_dis_d = short_dis_d | short_set;
    end

    // fault state registers
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            lat_q <= {`FMA_LAT_W{1'b0}};
            short_dis_q <= 2'h0;
        end else if (ce_i) begin
            lat_q <= lat_d;
            short_dis_q <= short_dis_d;
        end
    end

    // summary over every latched bit of both registers
    assign summary = |lat_q;

    // live fault: any present fault except stall, or a short-disabled phase
    assign fault_any = supply_low | s_hot | s_cold | s_ot | (|s_short) | (|s_open) |
                       (|short_dis_q);

    // status pin source select
    always @* begin
        pin_d = ~fault_any;
        case (ctrl_sel_q)
            `FMA_SEL_FAULT: pin_d = ~fault_any;
            `FMA_SEL_STALL: pin_d = ~s_stall;
            `FMA_SEL_PWMA: pin_d = pwm_a_on_i;
            default: pin_d = 1'b0; // temperature carried by the analog path
        endcase
    end

    // registered bridge, threshold and status outputs
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            bridge_en_a_q <= 1'b0;
            bridge_en_b_q <= 1'b0;
            thr_low_q <= 1'b0;
            fault_live_n_q <= 1'b1;
            pin_q <= 1'b1;
            temp_sel_q <= 1'b0;
        end else if (ce_i) begin
            // regulator low or overtemperature stop both phases
            bridge_en_a_q <= ~s_regulator_output & ~s_ot & ~short_dis_d[0];
            bridge_en_b_q <= ~s_regulator_output & ~s_ot & ~short_dis_d[1];
            thr_low_q <= s_vbb;
            fault_live_n_q <= ~fault_any;
            pin_q <= pin_d;
            temp_sel_q <= (ctrl_sel_q == `FMA_SEL_TEMP);
        end
    end

    assign bridge_en_a_o = bridge_en_a_q;
    assign bridge_en_b_o = bridge_en_b_q;
    assign regulator_output_thr_low_o = thr_low_q;
    assign fault_live_n_o = fault_live_n_q;
    assign status_indicator_pin_o = pin_q;
    assign temp_analog_sel_o = temp_sel_q;

    // summary leads the serial frame as soon as the strobe falls
    assign serial_first_bit_o = ~frame_select_n_i & summary;

    // diagnostic register images
    assign diag0 = {summary, lat_q[`FMA_LAT_SUPPLY], lat_q[`FMA_LAT_SHORT_HI:`FMA_LAT_SHORT_LO],
                    lat_q[`FMA_LAT_OPEN_HI:`FMA_LAT_OPEN_LO], 8'h00};
    assign diag1 = {summary, lat_q[`FMA_LAT_SUPPLY], lat_q[`FMA_LAT_TSD], lat_q[`FMA_LAT_HOT],
                    lat_q[`FMA_LAT_COLD], lat_q[`FMA_LAT_STALL], 10'h000};

    // interrupt events on rising fault indications
    assign ev_src = {s_stall, |s_open, |s_short, s_ot, s_cold, s_hot, supply_low};
    assign ev_rise = ev_src & ~ev_prev_q;

    // apb access phase and completion
    assign acc = psel_i & penable_i;
    assign done = acc & rdy_q;
    assign wr_done = done & pwrite_i & ~err_q &
                     ((paddr_i == `FMA_OFF_DIAG0) || (paddr_i == `FMA_OFF_DIAG1));

    // read data and address decode
    always @* begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        if (paddr_i == `FMA_OFF_DIAG0) begin
            rd_data = {16'h0000, diag0};
        end else if (paddr_i == `FMA_OFF_DIAG1) begin
            rd_data = {16'h0000, diag1};
        end else if (paddr_i == `FMA_OFF_CTRL) begin
            rd_data = {30'h0000_0000, ctrl_sel_q};
        end else if (paddr_i == `FMA_OFF_IRQ_STAT) begin
            rd_data = {25'h000_0000, irq_stat_q};
        end else if (paddr_i == `FMA_OFF_IRQ_MASK) begin
            rd_data = {25'h000_0000, irq_mask_q};
        end else begin
            rd_err = 1'b1;
        end
    end

    // sticky status: read clears, a new event in the same cycle wins
    always @* begin
        irq_stat_d = irq_stat_q;
        if (done && !pwrite_i && (paddr_i == `FMA_OFF_IRQ_STAT)) begin
            irq_stat_d = {`FMA_EV_W{1'b0}};
        end
        irq_stat_d = irq_stat_d | ev_rise;
    end

    // apb slave: one wait state, data captured before ready
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rdy_q <= 1'b0;
            err_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            ctrl_sel_q <= `FMA_CTRL_RST;
            irq_mask_q <= `FMA_MASK_RST;
        end else if (ce_i) begin
            if (done) begin
                rdy_q <= 1'b0;
                err_q <= 1'b0;
                if (pwrite_i && !err_q) begin
                    if (paddr_i == `FMA_OFF_CTRL) begin
                        ctrl_sel_q <= pwdata_i[`FMA_CTRL_SEL_HI:`FMA_CTRL_SEL_LO];
                    end else if (paddr_i == `FMA_OFF_IRQ_MASK) begin
                        irq_mask_q <= pwdata_i[`FMA_EV_W-1:0];
                    end
                end
            end else if (acc) begin
                rdy_q <= 1'b1;
                err_q <= rd_err;
                prdata_q <= pwrite_i ? 32'h0000_0000 : rd_data;
            end
        end
    end

    // interrupt state
    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= {`FMA_EV_W{1'b0}};
            ev_prev_q <= {`FMA_EV_W{1'b0}};
            irq_q <= 1'b0;
        end else if (ce_i) begin
            irq_stat_q <= irq_stat_d;
            ev_prev_q <= ev_src;
            irq_q <= |(irq_stat_d & irq_mask_q);
        end
    end

    assign pready_o = rdy_q;
    assign pslverr_o = rdy_q & err_q;
    assign prdata_o = prdata_q;
    assign irq_o = irq_q;

endmodule // fma_top

`default_nettype wire

/* tb/fma_cmp_model.sv */
// comparator bank model feeding asynchronous fault levels
`timescale 1ns/1ps
`default_nettype none
module fma_cmp_model (
    // clock and commanded levels
    input wire logic clk_i,
    input wire logic [11:0] lvl_i,
    // comparator outputs
    output logic [11:0] cmp_o
);
    // levels move on the falling edge, unrelated to sampling
    initial cmp_o = 12'h000;
    always @(negedge clk_i) begin
        cmp_o <= lvl_i;
    end
endmodule // fma_cmp_model
`default_nettype wire

/* tb/fma_top_assertions.sv */
// checker for the fault monitor aggregator ports
`timescale 1ns/1ps
`default_nettype none
module fma_top_chk #(
    parameter ADDR_W = 8
) (
    // clock, resets and enable
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic logic_uv_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // comparator levels
    input wire logic regulator_output_uv_i,
    input wire logic motor_supply_uv_i,
    input wire logic hot_warn_i,
    input wire logic cold_warn_i,
    input wire logic overtemp_i,
    // pins and outputs
    input wire logic frame_select_n_i,
    input wire logic bridge_en_a_o,
    input wire logic bridge_en_b_o,
    input wire logic regulator_output_thr_low_o,
    input wire logic fault_live_n_o,
    input wire logic serial_first_bit_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    // frozen cycles carry no obligations
    default disable iff (!rst_n_i || logic_uv_i || !ce_i);

    // supply, thermal, serial and handshake relations
    AST_REGULATOR_OUTPUT_OFF: assert property (regulator_output_uv_i [*3] |=> !bridge_en_a_o && !bridge_en_b_o)
        else $error("bridge stays on under regulator undervoltage");
    AST_THR_LOW: assert property (motor_supply_uv_i [*3] |=> regulator_output_thr_low_o)
        else $error("low threshold not selected");
    AST_UV_LIVE: assert property ((regulator_output_uv_i || motor_supply_uv_i) [*3] |=> !fault_live_n_o)
        else $error("undervoltage not flagged live");
    AST_WARN_LIVE: assert property ((hot_warn_i || cold_warn_i) [*3] |=> !fault_live_n_o)
        else $error("warning not flagged live");
    AST_OT_OFF: assert property (overtemp_i [*3] |=> !bridge_en_a_o && !fault_live_n_o)
        else $error("overtemperature not acted on");
    AST_OFF_LIVE: assert property (!bridge_en_a_o && $past(bridge_en_a_o) |-> !fault_live_n_o)
        else $error("bridge off without live fault");
    AST_SYNC_LAT: assert property ($rose(overtemp_i) && bridge_en_a_o |=> bridge_en_a_o)
        else $error("comparator acted on before synchronising");
    AST_SER_IDLE: assert property (frame_select_n_i |-> !serial_first_bit_o)
        else $error("serial bit driven outside frame");
    AST_PREADY: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("access phase not answered in one wait");
    AST_SLVERR: assert property (pready_o && paddr_i > 8'h10 |-> pslverr_o)
        else $error("unmapped access without error");

    // main scenarios
    CV_ERR: cover property (pslverr_o);
    CV_SHORT: cover property (!bridge_en_a_o && bridge_en_b_o);
    CV_SER: cover property (serial_first_bit_o);
endmodule // fma_top_chk

bind fma_top fma_top_chk #(.ADDR_W(ADDR_W)) u_chk (.clk_i, .rst_n_i, .ce_i, .logic_uv_i, .psel_i, .penable_i,
    .paddr_i, .pready_o, .pslverr_o, .regulator_output_uv_i, .motor_supply_uv_i, .hot_warn_i,
    .cold_warn_i, .overtemp_i, .frame_select_n_i, .bridge_en_a_o, .bridge_en_b_o,
    .regulator_output_thr_low_o, .fault_live_n_o, .serial_first_bit_o);
`default_nettype wire

/* tb/test_fma_top.sv */
// self-checking bench for the fault monitor aggregator
`timescale 1ns/1ps
`default_nettype none
module test_fma_top;
    logic clk_i, rst_n_i, ce_i, logic_uv_i, psel_i, penable_i, pwrite_i, er;
    logic step_i, hard_clear_n_i, frame_select_n_i, pwm_a_on_i;
    logic [7:0] paddr_i;
    logic [31:0] pwdata_i, rd;
    logic [11:0] lvl;
    wire [11:0] cmp;
    wire [31:0] prdata_o;
    wire [3:0] short_i;
    wire [1:0] open_load_i;
    wire pready_o, pslverr_o, regulator_output_uv_i, motor_supply_uv_i, hot_warn_i, cold_warn_i;
    wire overtemp_i, stall_i, bridge_en_a_o, bridge_en_b_o, regulator_output_thr_low_o, fault_live_n_o;
    wire status_indicator_pin_o, temp_analog_sel_o, serial_first_bit_o, irq_o;
    int err_count = 0;
    int check_count = 0;

    // comparator side and device
    assign {stall_i, open_load_i, short_i, overtemp_i, cold_warn_i, hot_warn_i, motor_supply_uv_i,
        regulator_output_uv_i} = cmp;
    fma_cmp_model u_cmp (.clk_i(clk_i), .lvl_i(lvl), .cmp_o(cmp));
    fma_top u_dut (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .psel_i(psel_i),
        .penable_i(penable_i),
        .pwrite_i(pwrite_i),
        .paddr_i(paddr_i),
        .pwdata_i(pwdata_i),
        .prdata_o(prdata_o),
        .pready_o(pready_o),
        .pslverr_o(pslverr_o),
        .logic_uv_i(logic_uv_i),
        .regulator_output_uv_i(regulator_output_uv_i),
        .motor_supply_uv_i(motor_supply_uv_i),
        .hot_warn_i(hot_warn_i),
        .cold_warn_i(cold_warn_i),
        .overtemp_i(overtemp_i),
        .short_i(short_i),
        .open_load_i(open_load_i),
        .stall_i(stall_i),
        .step_i(step_i),
        .hard_clear_n_i(hard_clear_n_i),
        .frame_select_n_i(frame_select_n_i),
        .pwm_a_on_i(pwm_a_on_i),
        .bridge_en_a_o(bridge_en_a_o),
        .bridge_en_b_o(bridge_en_b_o),
        .regulator_output_thr_low_o(regulator_output_thr_low_o),
        .fault_live_n_o(fault_live_n_o),
        .status_indicator_pin_o(status_indicator_pin_o),
        .temp_analog_sel_o(temp_analog_sel_o),
        .serial_first_bit_o(serial_first_bit_o),
        .irq_o(irq_o)
    );

    // clock
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    task automatic close_out();
        if (err_count == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic wt(input int c);
        repeat (c) @(posedge clk_i);
    endtask

    // one apb transfer, waits for pready; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic hclr();
        hard_clear_n_i <= 1'b0;
        wt(2);
        hard_clear_n_i <= 1'b1;
    endtask

    // reset values of all five registers and of the bridge, live fault and status pins
    task automatic t_regs();
        for (int k = 0; k < 5; k++) begin
            apb(1'b0, 8'(k * 4), 32'h0);
            chk(rd, 33'h0);
        end
        chk({bridge_en_a_o, bridge_en_b_o, fault_live_n_o, status_indicator_pin_o}, 33'hF);
    endtask

    // one fault source: live effect, latch, summary, clear
    task automatic t_fault(input int i, input logic br, input logic [31:0] d);
        lvl <= 12'h001 << i;
        wt(5);
        chk({bridge_en_a_o, bridge_en_b_o, fault_live_n_o}, {br, br, 1'b0});
        chk(regulator_output_thr_low_o, i == 1);
        lvl <= 12'h000;
        wt(5);
        chk({bridge_en_a_o, fault_live_n_o, regulator_output_thr_low_o}, 33'h6);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, d);
        frame_select_n_i <= 1'b0;
        wt(1);
        chk(serial_first_bit_o, 1'b1);
        frame_select_n_i <= 1'b1;
        if (i[0]) apb(1'b1, 8'h00, 32'h0);
        else hclr();
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 33'h0);
    endtask

    // latched short, step release
    task automatic t_short();
        lvl <= 12'h010 << 1;
        wt(5);
        chk({bridge_en_a_o, bridge_en_b_o, fault_live_n_o}, 33'h2);
        lvl <= 12'h000;
        wt(5);
        chk({bridge_en_a_o, fault_live_n_o}, 33'h0);
        step_i <= 1'b1;
        wt(3);
        step_i <= 1'b0;
        chk({bridge_en_a_o, fault_live_n_o}, 33'h3);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 33'h8400);
        apb(1'b1, 8'h04, 32'h0);
        apb(1'b0, 8'h00, 32'h0);
        chk(rd, 33'h0);
    endtask

    // status pin sources and unmapped access
    task automatic t_pin();
        apb(1'b1, 8'h08, 32'h1);
        lvl <= 12'h800;
        wt(5);
        chk({status_indicator_pin_o, fault_live_n_o}, 33'h1);
        lvl <= 12'h000;
        apb(1'b1, 8'h08, 32'h2);
        pwm_a_on_i <= 1'b1;
        wt(2);
        chk(status_indicator_pin_o, 1'b1);
        pwm_a_on_i <= 1'b0;
        wt(2);
        chk(status_indicator_pin_o, 1'b0);
        apb(1'b1, 8'h08, 32'h3);
        wt(2);
        chk({status_indicator_pin_o, temp_analog_sel_o}, 33'h1);
        apb(1'b1, 8'h08, 32'h0);
        wt(2);
        chk({status_indicator_pin_o, temp_analog_sel_o}, 33'h2);
        apb(1'b0, 8'h20, 32'h0);
        chk({er, rd}, 33'h100000000);
        hclr();
    endtask

    // clock enable low freezes the block, high lets the warning through
    task automatic t_ce();
        ce_i <= 1'b0;
        lvl <= 12'h004;
        wt(6);
        chk(fault_live_n_o, 1'b1);
        ce_i <= 1'b1;
        wt(4);
        chk(fault_live_n_o, 1'b0);
        lvl <= 12'h000;
        wt(4);
        hclr();
    endtask

    // logic undervoltage holds everything in reset, then control and diag1 defaults return
    task automatic t_luv();
        apb(1'b1, 8'h08, 32'h1);
        lvl <= 12'h004;
        wt(5);
        lvl <= 12'h000;
        logic_uv_i <= 1'b1;
        wt(3);
        chk({bridge_en_a_o, fault_live_n_o, status_indicator_pin_o}, 33'h3);
        logic_uv_i <= 1'b0;
        wt(5);
        apb(1'b0, 8'h08, 32'h0);
        chk(rd, 33'h0);
        apb(1'b0, 8'h04, 32'h0);
        chk(rd, 33'h0);
    endtask

    // interrupt raise, mask, read clear
    task automatic t_irq();
        apb(1'b0, 8'h0C, 32'h0);
        apb(1'b1, 8'h10, 32'h2);
        lvl <= 12'h004;
        wt(5);
        lvl <= 12'h008;
        wt(5);
        lvl <= 12'h000;
        wt(5);
        chk(irq_o, 1'b1);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 33'h6);
        wt(2);
        chk(irq_o, 1'b0);
        apb(1'b0, 8'h0C, 32'h0);
        chk(rd, 33'h0);
        hclr();
    endtask

    // main sequence
    initial begin
        rst_n_i = 1'b0;
        ce_i = 1'b1;
        logic_uv_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        step_i = 1'b0;
        hard_clear_n_i = 1'b1;
        frame_select_n_i = 1'b1;
        pwm_a_on_i = 1'b0;
        lvl = 12'h000;
        wt(10);
        rst_n_i <= 1'b1;
        wt(5);
        t_regs();
        t_fault(0, 1'b0, 32'hC000);
        t_fault(1, 1'b1, 32'hC000);
        t_fault(2, 1'b1, 32'h9000);
        t_fault(3, 1'b1, 32'h8800);
        t_fault(4, 1'b0, 32'hA000);
        t_short();
        t_pin();
        t_ce();
        t_luv();
        t_irq();
        close_out();
    end

    // watchdog
    initial begin
        #100000;
        err_count++;
        close_out();
    end
endmodule // test_fma_top
`default_nettype wire
